/* rtl/fesu_fault_unit.sv */
`timescale 1ns/1ps
`default_nettype none

module fesu_fault_unit
    import fesu_pkg::*;
#(
    parameter bit REDUCED = 1'b0,
    parameter bit SEC_EXT = 1'b1,
    parameter int PRIO_BITS = 3
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Fault events from the pipeline
    input wire fesu_fault_t fault_i,
    // Handler enables and priorities: prot, bus, exec, sec
    input wire logic [3:0] fault_en_i,
    input wire logic [3:0][PRIO_BITS-1:0] cls_prio_i,
    input wire logic signed [FESU_PRIO_W-1:0] exec_prio_i,
    // Debug controls
    input wire logic halt_dbg_en_i,
    input wire logic [4:0] vc_en_i,
    // Register access port
    input wire fesu_reg_req_t reg_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_ack_o,
    output logic reg_err_o,
    // Exception request to the core
    output logic exc_valid_o,
    output logic [3:0] exc_num_o,
    output logic signed [FESU_PRIO_W-1:0] exc_prio_o,
    output logic debug_halt_o
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // A configurable level must stay positive inside the signed range.
    if (PRIO_BITS < 1 || PRIO_BITS > FESU_PRIO_W - 1) begin : g_bad_prio
        $error("PRIO_BITS out of range");
    end

    localparam bit STAT_EN = !REDUCED;
    localparam bit SEC_EN = SEC_EXT && !REDUCED;

    // ------------------------------------------------------------
    // Fault classification
    // ------------------------------------------------------------
    fesu_cls_t cls;
    logic [1:0] cidx;
    logic cfg_route;
    logic signed [FESU_PRIO_W-1:0] cfg_prio;
    logic preempt;
    logic take_cfg;
    logic escalate;
    logic sec_ns_nmi;
    logic [3:0] tgt_num;
    logic signed [FESU_PRIO_W-1:0] tgt_prio;
    logic [2:0] tgt_idx;
    logic vc_hit;

    assign cls = fault_i.cls;
    assign cidx = 2'(cls - 3'h1);
    // Outside the reduced profile, protection, bus and execution classes come straight from
    // their sources; security joins them when SEC_EXT is set and maps to default otherwise.
    assign cfg_route = !REDUCED && (cls != FESU_FC_DEFAULT)
        && (cls != FESU_FC_SEC || SEC_EXT);
    assign cfg_prio = signed'(FESU_PRIO_W'(cls_prio_i[cidx]));
    assign preempt = cfg_prio < exec_prio_i;
    // Enables come from the fault_en_i input; this block does not reset them.
    assign take_cfg = fault_i.valid && cfg_route
        && fault_en_i[cidx] && preempt;
    assign escalate = fault_i.valid && cfg_route && !take_cfg;
    assign sec_ns_nmi = (cls == FESU_FC_SEC) && fault_i.ns_nmi;
    assign tgt_num = take_cfg ? 4'(cls) + FESU_EXC_DEFAULT
        : FESU_EXC_DEFAULT;
    assign tgt_prio = take_cfg ? cfg_prio
        : sec_ns_nmi ? FESU_PRIO_NS_NMI
        : FESU_PRIO_DEFAULT;
    assign tgt_idx = take_cfg ? 3'(cls) : 3'h0;
    assign vc_hit = fault_i.valid && halt_dbg_en_i
        && vc_en_i[tgt_idx];

    // ------------------------------------------------------------
    // Status set terms
    // ------------------------------------------------------------
    logic rec;
    logic [31:0] prot_set;
    logic [31:0] bus_set;
    logic [31:0] exec_set;
    logic [31:0] sec_set;
    logic [FESU_NUM_STAT-1:0][31:0] stat_set;
    logic [FESU_NUM_STAT-1:0][31:0] stat_clr;
    logic [FESU_NUM_STAT-1:0][31:0] stat_q;

    assign rec = fault_i.valid && STAT_EN;
    assign prot_set = (rec && cls == FESU_FC_PROT)
        ? ((32'(fault_i.syn[6:0]) << FESU_PROT_LSB)
        | (32'(fault_i.addr_ok) << FESU_PROT_AVALID_BIT))
        : 32'h0000_0000;
    assign bus_set = (rec && cls == FESU_FC_BUS)
        ? ((32'(fault_i.syn[6:0]) << FESU_BUS_LSB)
        | (32'(fault_i.addr_ok) << FESU_BUS_AVALID_BIT))
        : 32'h0000_0000;
    assign exec_set = (rec && cls == FESU_FC_EXEC)
        ? (32'(fault_i.syn) << FESU_EXEC_LSB)
        : 32'h0000_0000;
    assign sec_set = (fault_i.valid && SEC_EN && cls == FESU_FC_SEC)
        ? (32'(fault_i.syn[5:0])
        | (32'(fault_i.addr_ok) << FESU_SEC_AVALID_BIT))
        : 32'h0000_0000;

    assign stat_set[FESU_SI_CFG] = prot_set | bus_set | exec_set;
    assign stat_set[FESU_SI_DEF] =
        (32'(escalate && STAT_EN) << FESU_DEF_ESC_BIT)
        | (32'(rec && cls == FESU_FC_DEFAULT && fault_i.vect)
        << FESU_DEF_VECT_BIT);
    assign stat_set[FESU_SI_DBG] =
        32'(vc_hit && STAT_EN) << FESU_DBG_VCATCH_BIT;
    assign stat_set[FESU_SI_SEC] = sec_set;

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    fesu_state_t state_reg;
    fesu_state_t state_next;
    logic [29:0] wa;
    logic [6:0] hit;
    logic [3:0] stat_hit;
    logic [3:0] bmask;
    logic [31:0] wmask;
    logic align_ok;
    logic mapped;
    logic take;
    logic acc_ok;
    logic wr_ok;

    assign wa = reg_i.addr[31:2];
    // Status words first, then address words, one word apart; the security status and address pair follows at EDE4.
    assign hit[0] = wa == FESU_CFG_STAT_ADDR[31:2];
    assign hit[1] = wa == FESU_DEF_STAT_ADDR[31:2];
    assign hit[2] = wa == FESU_DBG_STAT_ADDR[31:2];
    assign hit[3] = wa == FESU_PROT_ADDR_ADDR[31:2];
    assign hit[4] = wa == FESU_BUS_ADDR_ADDR[31:2];
    assign hit[5] = SEC_EN && wa == FESU_SEC_STAT_ADDR[31:2];
    assign hit[6] = SEC_EN && wa == FESU_SEC_ADDR_ADDR[31:2];
    assign stat_hit = {hit[5], hit[2], hit[1], hit[0]};

    // Byte and halfword lanes let software clear one field alone.
    assign bmask = (reg_i.size == FESU_SZ_WORD) ? 4'hF
        : (reg_i.size == FESU_SZ_HALF)
        ? (reg_i.addr[1] ? 4'hC : 4'h3)
        : (4'h1 << reg_i.addr[1:0]);
    assign wmask = {{8{bmask[3]}}, {8{bmask[2]}},
        {8{bmask[1]}}, {8{bmask[0]}}};
    assign align_ok = (reg_i.size == FESU_SZ_WORD)
        ? (reg_i.addr[1:0] == 2'h0)
        : (reg_i.size == FESU_SZ_HALF) ? !reg_i.addr[0]
        : (reg_i.size == FESU_SZ_BYTE);
    assign mapped = STAT_EN && (|hit);
    assign take = reg_i.req && (state_reg == FESU_ST_IDLE);
    assign acc_ok = take && reg_i.priv && mapped && align_ok;
    assign wr_ok = acc_ok && reg_i.write;

    always_comb begin
        case (state_reg)
            FESU_ST_IDLE: state_next = take ? FESU_ST_ANSWER : FESU_ST_IDLE;
            FESU_ST_ANSWER: state_next = FESU_ST_IDLE;
            default: state_next = FESU_ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Sticky status registers
    // ------------------------------------------------------------
    for (genvar i = 0; i < FESU_NUM_STAT; i++) begin : g_stat
        assign stat_clr[i] = (wr_ok && stat_hit[i])
            ? (reg_i.wdata & wmask) : 32'h0000_0000;
        fesu_sticky_reg #(
            .WIDTH(32)
        ) u_stat (
            .ref_clk_i(ref_clk_i),
            .reset_i(reset_i),
            .set_i(stat_set[i]),
            .clr_i(stat_clr[i]),
            .q_o(stat_q[i])
        );
    end

    // ------------------------------------------------------------
    // Fault address registers
    // ------------------------------------------------------------
    logic [31:0] prot_addr_reg;
    logic [31:0] bus_addr_reg;
    logic [31:0] sec_addr_reg;
    logic [31:0] prot_addr_next;
    logic [31:0] bus_addr_next;
    logic [31:0] sec_addr_next;
    logic cap_prot;
    logic cap_bus;
    logic cap_sec;

    assign cap_prot = prot_set[FESU_PROT_AVALID_BIT];
    assign cap_bus = bus_set[FESU_BUS_AVALID_BIT];
    assign cap_sec = sec_set[FESU_SEC_AVALID_BIT];
    // A capture in the same cycle as a software write wins.
    assign prot_addr_next = cap_prot ? fault_i.addr
        : (wr_ok && hit[3])
        ? ((prot_addr_reg & ~wmask) | (reg_i.wdata & wmask))
        : prot_addr_reg;
    assign bus_addr_next = cap_bus ? fault_i.addr
        : (wr_ok && hit[4])
        ? ((bus_addr_reg & ~wmask) | (reg_i.wdata & wmask))
        : bus_addr_reg;
    assign sec_addr_next = cap_sec ? fault_i.addr
        : (wr_ok && hit[6])
        ? ((sec_addr_reg & ~wmask) | (reg_i.wdata & wmask))
        : sec_addr_reg;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            prot_addr_reg <= FESU_ADDR_RST;
            bus_addr_reg <= FESU_ADDR_RST;
            sec_addr_reg <= FESU_ADDR_RST;
        end else begin
            prot_addr_reg <= prot_addr_next;
            bus_addr_reg <= bus_addr_next;
            sec_addr_reg <= sec_addr_next;
        end
    end

    // ------------------------------------------------------------
    // Read data and answer
    // ------------------------------------------------------------
    logic [31:0] rsel;
    logic [31:0] rdata_next;

    assign rsel = hit[0] ? stat_q[FESU_SI_CFG]
        : hit[1] ? stat_q[FESU_SI_DEF]
        : hit[2] ? stat_q[FESU_SI_DBG]
        : hit[3] ? prot_addr_reg
        : hit[4] ? bus_addr_reg
        : hit[5] ? stat_q[FESU_SI_SEC]
        : hit[6] ? sec_addr_reg
        : 32'h0000_0000;
    // Refused reads return zero so nothing leaks to user code.
    assign rdata_next = (acc_ok && !reg_i.write)
        ? (rsel & wmask) : 32'h0000_0000;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_reg <= FESU_ST_IDLE;
            reg_ack_o <= 1'b0;
            reg_err_o <= 1'b0;
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            reg_ack_o <= take;
            reg_err_o <= take && !acc_ok;
            reg_rdata_o <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Exception request
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            exc_valid_o <= 1'b0;
            exc_num_o <= 4'h0;
            exc_prio_o <= '0;
            debug_halt_o <= 1'b0;
        end else begin
            exc_valid_o <= fault_i.valid;
            exc_num_o <= fault_i.valid ? tgt_num : 4'h0;
            exc_prio_o <= fault_i.valid ? tgt_prio : '0;
            debug_halt_o <= vc_hit;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    property p_reduced_default;
        fault_i.valid && REDUCED |=> exc_num_o == FESU_EXC_DEFAULT;
    endproperty
    a_reduced_default: assert property (p_reduced_default)
        else $error("reduced profile fault not routed to default");

    property p_default_prio;
        fault_i.valid && !take_cfg && !sec_ns_nmi
            |=> exc_prio_o == FESU_PRIO_DEFAULT;
    endproperty
    a_default_prio: assert property (p_default_prio)
        else $error("default fault priority not -1");

    property p_nsnmi_prio;
        fault_i.valid && !take_cfg && sec_ns_nmi
            |=> exc_prio_o == FESU_PRIO_NS_NMI && exc_valid_o;
    endproperty
    a_nsnmi_prio: assert property (p_nsnmi_prio)
        else $error("non-secure NMI violation priority not -3");

    property p_escalate;
        fault_i.valid && cfg_route && !fault_en_i[cidx]
            |=> exc_num_o == FESU_EXC_DEFAULT
            && stat_q[FESU_SI_DEF][FESU_DEF_ESC_BIT];
    endproperty
    a_escalate: assert property (p_escalate)
        else $error("disabled fault did not escalate");

    property p_cfg_prio;
        take_cfg |=> exc_prio_o == $past(cfg_prio) && exc_num_o > 4'h3;
    endproperty
    a_cfg_prio: assert property (p_cfg_prio)
        else $error("configurable priority not carried");

    property p_unpriv;
        take && !reg_i.priv
            |=> reg_ack_o && reg_err_o && reg_rdata_o == 32'h0000_0000;
    endproperty
    a_unpriv: assert property (p_unpriv)
        else $error("unprivileged access not refused");

    property p_addr_capture;
        fault_i.valid && STAT_EN && cls == FESU_FC_PROT && fault_i.addr_ok
            |=> prot_addr_reg == $past(fault_i.addr);
    endproperty
    a_addr_capture: assert property (p_addr_capture)
        else $error("protection fault address not captured");

    property p_vcatch;
        fault_i.valid && halt_dbg_en_i && vc_en_i[tgt_idx]
            |=> debug_halt_o && exc_valid_o
            ##1 debug_halt_o == $past(vc_hit);
    endproperty
    a_vcatch: assert property (p_vcatch)
        else $error("vector catch did not halt");

    property p_sticky;
        stat_q[FESU_SI_CFG][0] && !stat_clr[FESU_SI_CFG][0]
            |=> stat_q[FESU_SI_CFG][0];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("status bit dropped without clear");

    property p_reset_zero;
        $fell(reset_i) |-> stat_q == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("status not zero after reset");

    c_escalate: cover property (fault_i.valid && escalate);
    c_take_cfg: cover property (take_cfg ##1 exc_valid_o);
    c_w1c_byte: cover property (wr_ok && reg_i.size == FESU_SZ_BYTE);
    c_vcatch: cover property (debug_halt_o);

endmodule : fesu_fault_unit

`default_nettype wire

/* rtl/fesu_pkg.sv */
package fesu_pkg;

    // ------------------------------------------------------------
    // Register word addresses
    // ------------------------------------------------------------
    localparam logic [31:0] FESU_CFG_STAT_ADDR = 32'hE000ED28;
    localparam logic [31:0] FESU_DEF_STAT_ADDR = 32'hE000ED2C;
    localparam logic [31:0] FESU_DBG_STAT_ADDR = 32'hE000ED30;
    localparam logic [31:0] FESU_PROT_ADDR_ADDR = 32'hE000ED34;
    localparam logic [31:0] FESU_BUS_ADDR_ADDR = 32'hE000ED38;
    localparam logic [31:0] FESU_SEC_STAT_ADDR = 32'hE000EDE4;
    localparam logic [31:0] FESU_SEC_ADDR_ADDR = 32'hE000EDE8;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int FESU_EXEC_LSB = 16;
    localparam int FESU_BUS_LSB = 8;
    localparam int FESU_PROT_LSB = 0;
    localparam int FESU_PROT_AVALID_BIT = 7;
    localparam int FESU_BUS_AVALID_BIT = 15;
    localparam int FESU_SEC_AVALID_BIT = 6;
    localparam int FESU_DEF_VECT_BIT = 1;
    localparam int FESU_DEF_ESC_BIT = 30;
    localparam int FESU_DBG_VCATCH_BIT = 3;
    localparam logic [31:0] FESU_STAT_RST = 32'h0000_0000;
    localparam logic [31:0] FESU_ADDR_RST = 32'h0000_0000;

    // Index of each sticky status register in the status array.
    localparam int FESU_NUM_STAT = 4;
    localparam int FESU_SI_CFG = 0;
    localparam int FESU_SI_DEF = 1;
    localparam int FESU_SI_DBG = 2;
    localparam int FESU_SI_SEC = 3;

    // ------------------------------------------------------------
    // Priorities and exception numbers
    // ------------------------------------------------------------
    localparam int FESU_PRIO_W = 5;
    localparam logic signed [4:0] FESU_PRIO_DEFAULT = 5'h1F;
    localparam logic signed [4:0] FESU_PRIO_NS_NMI = 5'h1D;
    localparam logic [3:0] FESU_EXC_DEFAULT = 4'h3;

    typedef enum logic [2:0] {
        FESU_FC_DEFAULT = 3'h0,
        FESU_FC_PROT = 3'h1,
        FESU_FC_BUS = 3'h2,
        FESU_FC_EXEC = 3'h3,
        FESU_FC_SEC = 3'h4
    } fesu_cls_t;

    typedef enum logic [1:0] {
        FESU_SZ_BYTE = 2'h0,
        FESU_SZ_HALF = 2'h1,
        FESU_SZ_WORD = 2'h2
    } fesu_size_t;

    typedef enum logic {
        FESU_ST_IDLE = 1'b0,
        FESU_ST_ANSWER = 1'b1
    } fesu_state_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        fesu_cls_t cls;
        logic [15:0] syn;
        logic [31:0] addr;
        logic addr_ok;
        logic ns_nmi;
        logic vect;
    } fesu_fault_t;

    typedef struct packed {
        logic req;
        logic write;
        logic priv;
        fesu_size_t size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } fesu_reg_req_t;

endpackage : fesu_pkg

/* rtl/fesu_sticky_reg.sv */
`timescale 1ns/1ps
`default_nettype none

module fesu_sticky_reg
    import fesu_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Hardware sets and software write-one clears
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    // Stored flags
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] flag_reg;
    logic [WIDTH-1:0] flag_next;

    // A set arriving with its clear is kept, so no event is lost.
    assign flag_next = (flag_reg & ~clr_i) | set_i;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            flag_reg <= WIDTH'(FESU_STAT_RST);
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign q_o = flag_reg;

endmodule : fesu_sticky_reg

`default_nettype wire

/* bench/fesu_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

module fesu_core_model
    import fesu_pkg::*;
(
    // Clock
    input wire logic ref_clk_i,
    // Answers from the block
    input wire logic [31:0] rdata_i,
    input wire logic ack_i,
    input wire logic err_i,
    input wire logic exc_valid_i,
    input wire logic [3:0] exc_num_i,
    input wire logic signed [4:0] exc_prio_i,
    input wire logic halt_i,
    // Requests to the block
    output var fesu_fault_t fault_o,
    output var fesu_reg_req_t reg_o
);

    initial begin
        fault_o = '0;
        reg_o = '0;
    end

    // Holds the request until ack is seen or 20 cycles pass, so a slow answer is still met.
    task automatic xfer(input logic wr, input logic pv, input fesu_size_t sz,
        input logic [31:0] ad, input logic [31:0] wd,
        output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        reg_o <= '{1'b1, wr, pv, sz, ad, wd};
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ack_i !== 1'b1 && n < 20);
        rd = rdata_i;
        er = err_i;
        // Released lines other than the size change value so stale data cannot pass.
        reg_o <= '{1'b0, ~wr, ~pv, sz, ~ad, ~wd};
    endtask : xfer

    task automatic hit(input fesu_cls_t c, input logic [15:0] sy,
        input logic [31:0] ad, input logic ok, input logic nmi,
        output logic [10:0] ex);
        @(posedge ref_clk_i);
        // Default-class events stand for a vector fetch error.
        fault_o <= '{1'b1, c, sy, ad, ok, nmi, c == FESU_FC_DEFAULT};
        @(posedge ref_clk_i);
        fault_o <= '{1'b0, c, ~sy, ~ad, ~ok, ~nmi, 1'b1};
        @(posedge ref_clk_i);
        ex = {exc_valid_i, halt_i, exc_num_i, exc_prio_i};
    endtask : hit

endmodule : fesu_core_model

`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb
    import fesu_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [31:0] FA = 32'h2000_0040;
    localparam logic [31:0] MAP [7] = '{FESU_CFG_STAT_ADDR,
        FESU_DEF_STAT_ADDR, FESU_DBG_STAT_ADDR, FESU_PROT_ADDR_ADDR,
        FESU_BUS_ADDR_ADDR, FESU_SEC_STAT_ADDR, FESU_SEC_ADDR_ADDR};
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] fault_en_i = 4'h0;
    logic [3:0][2:0] cls_prio_i = {4{3'h2}};
    logic signed [4:0] exec_prio_i = 5'h04;
    logic halt_dbg_en_i = 1'b0;
    logic [4:0] vc_en_i = 5'h00;
    fesu_fault_t flt_w;
    fesu_reg_req_t rq_w;
    logic [31:0] rdata, r_rdata, d;
    logic ack, err, exc_v, halt, r_err, er;
    logic [3:0] exc_n, r_num;
    logic signed [4:0] exc_p;
    logic [10:0] ex;
    int n_mismatch = 0;
    int compares = 0;

    always #50 ref_clk_i = ~ref_clk_i;

    fesu_core_model core (.ref_clk_i, .rdata_i(rdata), .ack_i(ack),
        .err_i(err), .exc_valid_i(exc_v), .exc_num_i(exc_n),
        .exc_prio_i(exc_p), .halt_i(halt), .fault_o(flt_w), .reg_o(rq_w));

    fesu_fault_unit u_fesu_fault_unit (.ref_clk_i, .reset_i,
        .fault_i(flt_w), .fault_en_i, .cls_prio_i, .exec_prio_i,
        .halt_dbg_en_i, .vc_en_i, .reg_i(rq_w), .reg_rdata_o(rdata),
        .reg_ack_o(ack), .reg_err_o(err), .exc_valid_o(exc_v),
        .exc_num_o(exc_n), .exc_prio_o(exc_p), .debug_halt_o(halt));

    fesu_fault_unit #(.REDUCED(1'b1)) u_fesu_fault_unit_red (.ref_clk_i,
        .reset_i, .fault_i(flt_w), .fault_en_i, .cls_prio_i, .exec_prio_i,
        .halt_dbg_en_i, .vc_en_i, .reg_i(rq_w), .reg_rdata_o(r_rdata),
        .reg_ack_o(), .reg_err_o(r_err), .exc_valid_o(),
        .exc_num_o(r_num), .exc_prio_o(), .debug_halt_o());

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic rdx(input fesu_size_t sz, input logic [31:0] a, e);
        core.xfer(1'b0, 1'b1, sz, a, 32'h0, d, er);
        chk("rdata", d, e);
        chk("err", {31'h0, er}, 32'h0);
        chk("ack", {31'h0, ack}, 32'h1);
    endtask : rdx

    task automatic flt(input fesu_cls_t c, input logic [15:0] sy,
        input logic ok, nmi, input logic [3:0] n, input logic [4:0] p);
        core.hit(c, sy, FA, ok, nmi, ex);
        chk("exc", {22'h0, ex[10], ex[8:0]}, {22'h0, 1'b1, n, p});
    endtask : flt

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        foreach (MAP[i]) rdx(FESU_SZ_WORD, MAP[i], 32'h0);
        core.xfer(1'b0, 1'b1, FESU_SZ_WORD, 32'hE000_ED3C, 32'h0, d, er);
        chk("unmapped err", {31'h0, er}, 32'h1);
        core.xfer(1'b0, 1'b0, FESU_SZ_WORD, FESU_CFG_STAT_ADDR, 32'h0, d, er);
        chk("user err", {31'h0, er}, 32'h1);
        chk("reduced err", {31'h0, r_err}, 32'h1);
    endtask : t_reset

    task automatic t_escalate();
        flt(FESU_FC_PROT, 16'h0002, 1'b1, 1'b0, 4'h3, 5'h1F);
        chk("reduced num", {28'h0, r_num}, 32'h3);
        rdx(FESU_SZ_WORD, FESU_DEF_STAT_ADDR, 32'h4000_0000);
        rdx(FESU_SZ_WORD, FESU_CFG_STAT_ADDR, 32'h0000_0082);
        rdx(FESU_SZ_WORD, FESU_PROT_ADDR_ADDR, FA);
        core.xfer(1'b1, 1'b0, FESU_SZ_WORD, MAP[0], 32'hFFFF_FFFF, d, er);
        rdx(FESU_SZ_WORD, FESU_CFG_STAT_ADDR, 32'h0000_0082);
        core.xfer(1'b1, 1'b1, FESU_SZ_WORD, MAP[0], 32'hFFFF_FFFF, d, er);
        core.xfer(1'b1, 1'b1, FESU_SZ_WORD, MAP[1], 32'hFFFF_FFFF, d, er);
        rdx(FESU_SZ_WORD, FESU_CFG_STAT_ADDR, 32'h0);
    endtask : t_escalate

    task automatic t_classes();
        @(posedge ref_clk_i);
        fault_en_i <= 4'hF;
        flt(FESU_FC_PROT, 16'h0001, 1'b0, 1'b0, 4'h4, 5'h02);
        flt(FESU_FC_BUS, 16'h0001, 1'b1, 1'b0, 4'h5, 5'h02);
        flt(FESU_FC_EXEC, 16'h0001, 1'b0, 1'b0, 4'h6, 5'h02);
        flt(FESU_FC_SEC, 16'h0001, 1'b0, 1'b0, 4'h7, 5'h02);
        rdx(FESU_SZ_WORD, FESU_CFG_STAT_ADDR, 32'h0001_8101);
        rdx(FESU_SZ_WORD, FESU_BUS_ADDR_ADDR, FA);
        rdx(FESU_SZ_WORD, FESU_SEC_STAT_ADDR, 32'h0000_0001);
        rdx(FESU_SZ_BYTE, 32'hE000_ED29, 32'h0000_8100);
        rdx(FESU_SZ_HALF, 32'hE000_ED2A, 32'h0001_0000);
        core.xfer(1'b1, 1'b1, FESU_SZ_BYTE, 32'hE000_ED29, 32'h100, d, er);
        rdx(FESU_SZ_WORD, FESU_CFG_STAT_ADDR, 32'h0001_8001);
        @(posedge ref_clk_i);
        cls_prio_i[2] <= 3'h4;
        flt(FESU_FC_EXEC, 16'h0001, 1'b0, 1'b0, 4'h3, 5'h1F);
    endtask : t_classes

    task automatic t_nmi();
        @(posedge ref_clk_i);
        fault_en_i <= 4'h0;
        flt(FESU_FC_SEC, 16'h0001, 1'b0, 1'b1, 4'h3, 5'h1D);
        chk("reduced num", {28'h0, r_num}, 32'h3);
        flt(FESU_FC_DEFAULT, 16'h0000, 1'b0, 1'b0, 4'h3, 5'h1F);
        rdx(FESU_SZ_WORD, FESU_DEF_STAT_ADDR, 32'h4000_0002);
    endtask : t_nmi

    task automatic t_vcatch();
        @(posedge ref_clk_i);
        halt_dbg_en_i <= 1'b1;
        vc_en_i <= 5'h02;
        fault_en_i <= 4'h1;
        core.hit(FESU_FC_PROT, 16'h0001, FA, 1'b0, 1'b0, ex);
        chk("halt", {31'h0, ex[9]}, 32'h1);
        rdx(FESU_SZ_WORD, FESU_DBG_STAT_ADDR, 32'h0000_0008);
        @(posedge ref_clk_i);
        halt_dbg_en_i <= 1'b0;
        core.hit(FESU_FC_PROT, 16'h0001, FA, 1'b0, 1'b0, ex);
        chk("no halt", {31'h0, ex[9]}, 32'h0);
    endtask : t_vcatch

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic conclude();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (16) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_escalate();
        t_classes();
        t_nmi();
        t_vcatch();
        conclude();
    end

    // The run needs well under a thousand cycles; twenty thousand is slack.
    initial begin
        #2000000;
        n_mismatch++;
        conclude();
    end

endmodule : tb

`default_nettype wire
